// ==== logic/io_space_defs.svh ====
// Purpose: Offsets, field masks and decode limits of the I/O register space
// Assumes: Offsets are 6-bit I/O addresses; data space adds the mirror base
// Notes:   Masks mark bits that exist; every other bit reads as zero
`ifndef IO_SPACE_DEFS_SVH
`define IO_SPACE_DEFS_SVH

// Address map limits
`define IO_SPACE_TOP      8'h3f
`define IO_DS_BASE        8'h20
`define IO_EXT_BASE       8'h60
`define IO_BIT_LIMIT      6'h20
`define IO_RESET_VALUE    8'h00

// Register offsets (I/O addresses)
`define OFS_PORT_A_PINS   6'h00
`define OFS_PORT_A_DIR    6'h01
`define OFS_PORT_A_OUT    6'h02
`define OFS_PORT_B_PINS   6'h03
`define OFS_PORT_B_DIR    6'h04
`define OFS_PORT_B_OUT    6'h05
`define OFS_PORT_CTRL     6'h12
`define OFS_TIMER0_FLAGS  6'h15
`define OFS_TIMER1_FLAGS  6'h16
`define OFS_PCINT_FLAGS   6'h1b
`define OFS_EXT_FLAGS     6'h1c
`define OFS_EXT_MASK      6'h1d
`define OFS_SCRATCH0      6'h1e
`define OFS_NVM_CTRL      6'h1f
`define OFS_NVM_DATA      6'h20
`define OFS_NVM_ADDR_LO   6'h21
`define OFS_NVM_ADDR_HI   6'h22
`define OFS_PRESCALE_SYNC 6'h23
`define OFS_TIMER0_CTRL_A 6'h25
`define OFS_TIMER0_CTRL_B 6'h26
`define OFS_TIMER0_COUNT  6'h27
`define OFS_TIMER0_CMP_A  6'h28
`define OFS_SCRATCH1      6'h2a
`define OFS_SCRATCH2      6'h2b
`define OFS_SPI_CTRL      6'h2c
`define OFS_SPI_STATUS    6'h2d
`define OFS_SPI_DATA      6'h2e
`define OFS_COMP_CTRL     6'h30
`define OFS_DEBUG_DATA    6'h31
`define OFS_SLEEP_CTRL    6'h33

// Implemented bits of registers that are not full bytes
`define MSK_PORT_CTRL     8'h33
`define MSK_TIMER0_FLAGS  8'h03
`define MSK_TIMER1_FLAGS  8'h27
`define MSK_PCINT_FLAGS   8'h03
`define MSK_EXT_FLAGS     8'h03
`define MSK_EXT_MASK      8'h03
`define MSK_NVM_CTRL      8'h3f
`define MSK_PRESCALE_SYNC 8'h83
`define MSK_TIMER0_CTRL_A 8'hc3
`define MSK_TIMER0_CTRL_B 8'h87
`define MSK_SPI_STATUS    8'hc1
`define MSK_SLEEP_CTRL    8'h07
`define MSK_FULL          8'hff
`define MSK_NONE          8'h00

`endif

// ==== logic/io_space_pkg.sv ====
// Purpose: Types shared by the I/O register space decoder
// Assumes: One core request per cycle at most
// Notes:   Constants live in io_space_defs.svh
`default_nettype none
package io_space_pkg;

  // Kinds of core access that reach the register space
  typedef enum logic [3:0] {
    NO_ACCESS,
    IO_READ,
    IO_WRITE,
    DATA_LOAD,
    DATA_STORE,
    BIT_SET_INSTR,
    BIT_CLEAR_INSTR,
    SKIP_IF_IO_BIT_SET,
    SKIP_IF_IO_BIT_CLEAR
  } access_kind_type;

  // One core request
  typedef struct packed {
    access_kind_type kind;
    logic [7:0]      addr;
    logic [2:0]      bit_sel;
    logic [7:0]      wdata;
  } core_req_type;

  // Registered answer to the core
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       skip;
  } core_resp_type;

endpackage
`default_nettype wire

// ==== logic/io_register_space_decode.sv ====
// Purpose: Decode of the lower 64 I/O locations for an 8-bit core
// Assumes: Requests and hardware flag events are on sys_clk
// Notes:   Extended region above the mirror is decoded but holds nothing here
`include "io_space_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - I/O instructions use a 6-bit address from zero to 0x3F.
// - Every I/O register also appears in data space at address plus 0x20.
// - Extended region 0x60-0xFF is reachable only by load and store.
// - Bit set and clear work on I/O addresses below 0x20 only.
// - Bit test with skip works on I/O addresses below 0x20 only.
// - Status flags clear on writing one; writing zero leaves them.
// - Bit set or clear changes only the addressed bit.
// - Memory address bits above the top implemented bit are ignored.
module io_register_space_decode
  import io_space_pkg::*;
#(
  parameter int NVM_ADDR_WIDTH = 9
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  // Core access
  input  wire core_req_type              req,
  output var  core_resp_type             resp,
  // Port pins and drive
  input  wire logic [7:0]                port_a_pins,
  input  wire logic [7:0]                port_b_pins,
  output logic      [7:0]                port_a_dir,
  output logic      [7:0]                port_a_out,
  output logic      [7:0]                port_b_dir,
  output logic      [7:0]                port_b_out,
  // Hardware flag events, one-cycle pulses
  input  wire logic [7:0]                timer0_events,
  input  wire logic [7:0]                timer1_events,
  input  wire logic [7:0]                pin_change_events,
  input  wire logic [7:0]                ext_irq_events,
  // Steering towards peripherals
  output logic      [7:0]                ext_irq_mask,
  output logic      [NVM_ADDR_WIDTH-1:0] nvm_address
);

  localparam int HI_BITS = (NVM_ADDR_WIDTH > 8) ? NVM_ADDR_WIDTH - 8 : 0;
  localparam logic [7:0] NVM_LO_MASK = (NVM_ADDR_WIDTH >= 8) ? `MSK_FULL :
    8'((16'h0001 << NVM_ADDR_WIDTH) - 16'h0001);
  localparam logic [7:0] NVM_HI_MASK =
    8'((16'h0001 << HI_BITS) - 16'h0001);

  logic [7:0] io_mem      [64];
  logic [7:0] next_io_mem [64];
  logic [7:0] pin_a_meta, pin_a_sync, pin_b_meta, pin_b_sync;
  logic [5:0] idx;
  logic       in_range, do_write, do_read, do_test;
  logic [7:0] touched, wval, wmask, rval;

  // Stored bits at each I/O address; zero marks reserved space and the pin registers
  function automatic logic [7:0] write_mask(input logic [5:0] a);
    unique case (a)
      `OFS_PORT_A_DIR, `OFS_PORT_A_OUT, `OFS_PORT_B_DIR, `OFS_PORT_B_OUT,
      `OFS_SCRATCH0, `OFS_NVM_DATA, `OFS_TIMER0_COUNT, `OFS_TIMER0_CMP_A,
      `OFS_SCRATCH1, `OFS_SCRATCH2, `OFS_SPI_CTRL, `OFS_SPI_DATA,
      `OFS_COMP_CTRL, `OFS_DEBUG_DATA: write_mask = `MSK_FULL;
      `OFS_PORT_CTRL:     write_mask = `MSK_PORT_CTRL;
      `OFS_TIMER0_FLAGS:  write_mask = `MSK_TIMER0_FLAGS;
      `OFS_TIMER1_FLAGS:  write_mask = `MSK_TIMER1_FLAGS;
      `OFS_PCINT_FLAGS:   write_mask = `MSK_PCINT_FLAGS;
      `OFS_EXT_FLAGS:     write_mask = `MSK_EXT_FLAGS;
      `OFS_EXT_MASK:      write_mask = `MSK_EXT_MASK;
      `OFS_NVM_CTRL:      write_mask = `MSK_NVM_CTRL;
      `OFS_NVM_ADDR_LO:   write_mask = NVM_LO_MASK;
      `OFS_NVM_ADDR_HI:   write_mask = NVM_HI_MASK;
      `OFS_PRESCALE_SYNC: write_mask = `MSK_PRESCALE_SYNC;
      `OFS_TIMER0_CTRL_A: write_mask = `MSK_TIMER0_CTRL_A;
      `OFS_TIMER0_CTRL_B: write_mask = `MSK_TIMER0_CTRL_B;
      `OFS_SPI_STATUS:    write_mask = `MSK_SPI_STATUS;
      `OFS_SLEEP_CTRL:    write_mask = `MSK_SLEEP_CTRL;
      default:            write_mask = `MSK_NONE;
    endcase
  endfunction

  // Flag registers whose bits clear on a written one
  function automatic logic is_w1c(input logic [5:0] a);
    is_w1c = (a == `OFS_TIMER0_FLAGS) || (a == `OFS_TIMER1_FLAGS) ||
             (a == `OFS_PCINT_FLAGS) || (a == `OFS_EXT_FLAGS);
  endfunction

  // Pins come from outside the clock domain, so two stages first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_a_meta <= `IO_RESET_VALUE;
      pin_a_sync <= `IO_RESET_VALUE;
      pin_b_meta <= `IO_RESET_VALUE;
      pin_b_sync <= `IO_RESET_VALUE;
    end else begin
      pin_a_meta <= port_a_pins;
      pin_a_sync <= pin_a_meta;
      pin_b_meta <= port_b_pins;
      pin_b_sync <= pin_b_meta;
    end
  end

  // Address decode for both access paths
  always_comb begin
    idx      = req.addr[5:0];
    in_range = 1'b0;
    unique case (req.kind)
      IO_READ, IO_WRITE: begin
        in_range = 1'b1;
      end
      DATA_LOAD, DATA_STORE: begin
        // Mirror window only; the extended region has no register here
        in_range = (req.addr >= `IO_DS_BASE) &&
                   (req.addr < `IO_EXT_BASE);
        idx      = 6'(req.addr - `IO_DS_BASE);
      end
      BIT_SET_INSTR, BIT_CLEAR_INSTR,
      SKIP_IF_IO_BIT_SET, SKIP_IF_IO_BIT_CLEAR: begin
        in_range = (req.addr[5:0] < `IO_BIT_LIMIT);
      end
      NO_ACCESS: begin
        in_range = 1'b0;
      end
      default: begin
        in_range = 1'b0;
      end
    endcase
    do_write = in_range && (req.kind inside {IO_WRITE, DATA_STORE,
                            BIT_SET_INSTR, BIT_CLEAR_INSTR});
    do_read  = in_range && (req.kind inside {IO_READ, DATA_LOAD});
    do_test  = in_range && (req.kind inside {SKIP_IF_IO_BIT_SET,
                            SKIP_IF_IO_BIT_CLEAR});
  end

  // Bit operations touch one lane only, byte writes touch all
  always_comb begin
    touched = `MSK_FULL;
    wval    = req.wdata;
    if (req.kind == BIT_SET_INSTR) begin
      touched = 8'h01 << req.bit_sel;
      wval    = `MSK_FULL;
    end else if (req.kind == BIT_CLEAR_INSTR) begin
      touched = 8'h01 << req.bit_sel;
      wval    = `MSK_NONE;
    end
    wmask = touched & write_mask(idx);
  end

  // Read value; input pins show the synchronised level
  always_comb begin
    if (idx == `OFS_PORT_A_PINS) begin
      rval = pin_a_sync;
    end else if (idx == `OFS_PORT_B_PINS) begin
      rval = pin_b_sync;
    end else begin
      rval = io_mem[idx] & write_mask(idx);
    end
  end

  // Next register contents; hardware set wins over a clearing write
  always_comb begin
    next_io_mem = io_mem;
    if (do_write) begin
      if (is_w1c(idx)) begin
        // A bit set on a flag writes one there and so clears only it
        next_io_mem[idx] = io_mem[idx] & ~(wval & wmask);
      end else begin
        next_io_mem[idx] = (io_mem[idx] & ~wmask) | (wval & wmask);
      end
    end
    next_io_mem[`OFS_TIMER0_FLAGS] = next_io_mem[`OFS_TIMER0_FLAGS] |
      (timer0_events & `MSK_TIMER0_FLAGS);
    next_io_mem[`OFS_TIMER1_FLAGS] = next_io_mem[`OFS_TIMER1_FLAGS] |
      (timer1_events & `MSK_TIMER1_FLAGS);
    next_io_mem[`OFS_PCINT_FLAGS] = next_io_mem[`OFS_PCINT_FLAGS] |
      (pin_change_events & `MSK_PCINT_FLAGS);
    next_io_mem[`OFS_EXT_FLAGS] = next_io_mem[`OFS_EXT_FLAGS] |
      (ext_irq_events & `MSK_EXT_FLAGS);
  end

  // Register storage, one cycle per access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 64; i++) begin
        io_mem[i] <= `IO_RESET_VALUE;
      end
    end else begin
      io_mem <= next_io_mem;
    end
  end

  // Answer to the core one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      resp <= '0;
    end else begin
      resp.valid <= do_read || do_test;
      resp.data  <= do_read ? rval : `MSK_NONE;
      resp.skip  <= do_test &&
        (rval[req.bit_sel] == (req.kind == SKIP_IF_IO_BIT_SET));
    end
  end

  // Steering outputs are the storage flops themselves
  assign port_a_dir   = io_mem[`OFS_PORT_A_DIR];
  assign port_a_out   = io_mem[`OFS_PORT_A_OUT];
  assign port_b_dir   = io_mem[`OFS_PORT_B_DIR];
  assign port_b_out   = io_mem[`OFS_PORT_B_OUT];
  assign ext_irq_mask = io_mem[`OFS_EXT_MASK];
  if (NVM_ADDR_WIDTH > 8) begin : g_nvm_wide
    assign nvm_address = {io_mem[`OFS_NVM_ADDR_HI][HI_BITS-1:0],
                          io_mem[`OFS_NVM_ADDR_LO]};
  end else begin : g_nvm_narrow
    assign nvm_address = io_mem[`OFS_NVM_ADDR_LO][NVM_ADDR_WIDTH-1:0];
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_io_read_answer: assert property (
    req.kind == IO_READ |=> resp.valid ##1
      (!resp.valid || $past(do_read) || $past(do_test))
  ) else $error("I/O read not answered in one cycle");

  a_ds_mirror_store: assert property (
    req.kind == DATA_STORE && req.addr == 8'h3e
    |=> io_mem[`OFS_SCRATCH0] == $past(req.wdata)
  ) else $error("Mirrored store missed its I/O register");

  a_ext_no_effect: assert property (
    req.kind == DATA_STORE && req.addr >= `IO_EXT_BASE
    |=> $stable(port_a_out) && $stable(port_b_dir) && $stable(ext_irq_mask)
  ) else $error("Extended store changed an I/O register");

  a_bit_high_none: assert property (
    req.kind == BIT_SET_INSTR && req.addr[5:0] == `OFS_SCRATCH1
    |=> io_mem[`OFS_SCRATCH1] == $past(io_mem[`OFS_SCRATCH1])
  ) else $error("Bit set acted above the bit range");

  a_skip_result: assert property (
    req.kind == SKIP_IF_IO_BIT_SET && req.addr[5:0] == `OFS_SCRATCH0
    |=> resp.valid && resp.skip == $past(io_mem[`OFS_SCRATCH0][req.bit_sel])
  ) else $error("Skip decision wrong");

  a_w1c_clear: assert property (
    req.kind == IO_WRITE && req.addr[5:0] == `OFS_EXT_FLAGS &&
    ext_irq_events == 8'h00
    |=> io_mem[`OFS_EXT_FLAGS] ==
        ($past(io_mem[`OFS_EXT_FLAGS]) & ~$past(req.wdata))
  ) else $error("Flag write-one-to-clear wrong");

  a_bit_only_one: assert property (
    req.kind == BIT_CLEAR_INSTR && req.addr[5:0] == `OFS_PORT_A_OUT
    |=> (port_a_out | (8'h01 << $past(req.bit_sel))) ==
        ($past(port_a_out) | (8'h01 << $past(req.bit_sel)))
        && !port_a_out[$past(req.bit_sel)]
  ) else $error("Bit clear disturbed other bits");

  a_nvm_top_bits: assert property (
    (io_mem[`OFS_NVM_ADDR_HI] & ~NVM_HI_MASK) == 8'h00
  ) else $error("Unimplemented address bit stored");

  a_reserved_zero: assert property (
    req.kind == IO_READ && req.addr[5:0] == 6'h32 |=> resp.data == 8'h00
  ) else $error("Reserved address read not zero");

  a_set_wins: assert property (
    ext_irq_events[0] |=> io_mem[`OFS_EXT_FLAGS][0]
  ) else $error("Flag event lost against a clear");

  a_io_write_lands: assert property (
    req.kind == IO_WRITE && req.addr[5:0] == `OFS_SCRATCH0
    |=> io_mem[`OFS_SCRATCH0] == $past(req.wdata)
  ) else $error("I/O write not visible next cycle");

  a_write_silent: assert property (
    req.kind inside {IO_WRITE, DATA_STORE, BIT_SET_INSTR, BIT_CLEAR_INSTR}
    |=> !resp.valid
  ) else $error("Write produced a read answer");

  a_ds_mirror_load: assert property (
    req.kind == DATA_LOAD && req.addr == 8'h3e
    |=> resp.valid && resp.data == $past(io_mem[`OFS_SCRATCH0])
  ) else $error("Mirrored load missed its I/O register");

  a_ds_out_range: assert property (
    req.kind == DATA_LOAD &&
    (req.addr < `IO_DS_BASE || req.addr >= `IO_EXT_BASE)
    |=> !resp.valid
  ) else $error("Load outside the mirror was answered");

  a_test_high_none: assert property (
    req.kind inside {SKIP_IF_IO_BIT_SET, SKIP_IF_IO_BIT_CLEAR} &&
    req.addr[5:0] >= `IO_BIT_LIMIT
    |=> !resp.valid
  ) else $error("Bit test answered above the bit range");

  a_flag_clr_none: assert property (
    req.kind == BIT_CLEAR_INSTR && req.addr[5:0] == `OFS_TIMER1_FLAGS &&
    timer1_events == 8'h00
    |=> $stable(io_mem[`OFS_TIMER1_FLAGS])
  ) else $error("Bit clear changed a flag register");

  c_mirror_load: cover property (req.kind == DATA_LOAD && do_read);
  c_skip_taken:  cover property (do_test ##1 resp.skip);
  c_clear_race:  cover property (do_write && is_w1c(idx) && |ext_irq_events);
  c_port_clear:  cover property (req.kind == BIT_CLEAR_INSTR && do_write &&
                                 idx == `OFS_PORT_A_OUT);

endmodule // io_register_space_decode
`default_nettype wire

// ==== sim/core_model.sv ====
// Purpose: Processor core side of the register space, issuing accesses
// Assumes: Called just after a rising edge of sys_clk
// Notes:   A request is held until the caller issues the next one or idles
`timescale 1ns/1ps
`default_nettype none
module core_model
  import io_space_pkg::*;
(
  // Clock
  input  wire logic          sys_clk,
  // Request and answer
  output var  core_req_type  req,
  input  wire core_resp_type resp
);
  // Quiet bus until the first access
  initial req = '{NO_ACCESS, 8'h00, 3'h0, 8'h00};

  // One access; answer is taken one edge later while it stands
  task automatic access(input access_kind_type kind, input logic [7:0] addr,
                        input logic [2:0] bit_sel, input logic [7:0] wdata,
                        output core_resp_type got);
    req = '{kind, addr, bit_sel, wdata};
    @(posedge sys_clk);
    #1;
    got = resp;
  endtask

  // Drop the request for one cycle
  task automatic idle();
    req.kind = NO_ACCESS;
    @(posedge sys_clk);
    #1;
  endtask
endmodule // core_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the I/O register space decoder
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Some writes set reserved bits on purpose to see them dropped
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import io_space_pkg::*;
  logic          sys_clk, reset;
  core_req_type  req;
  core_resp_type resp, got;
  logic [7:0]    a_pins, b_pins, t0_ev, t1_ev, pc_ev, ext_ev;
  logic [7:0]    a_dir, a_out, b_dir, b_out, irq_mask;
  logic [8:0]    nvm_addr;
  int            errors, checks, cycles;
  // Writable places and the bits that survive a write of all ones
  localparam logic [7:0] wofs [28] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h12,
    8'h15, 8'h16, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22,
    8'h23, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e,
    8'h30, 8'h31, 8'h33};
  localparam logic [7:0] wmsk [28] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h33,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h01,
    8'h83, 8'hc3, 8'h87, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hc1, 8'hff,
    8'hff, 8'hff, 8'h07};
  // Bit test cases on a register holding 8'h04
  localparam access_kind_type tk [4] = '{SKIP_IF_IO_BIT_SET,
    SKIP_IF_IO_BIT_SET, SKIP_IF_IO_BIT_CLEAR, SKIP_IF_IO_BIT_CLEAR};
  localparam logic [2:0] tb_bit [4] = '{3'h2, 3'h3, 3'h3, 3'h2};
  localparam logic tskip [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  io_register_space_decode #(.NVM_ADDR_WIDTH(9)) DUT (
    .sys_clk(sys_clk), .reset(reset), .req(req), .resp(resp),
    .port_a_pins(a_pins), .port_b_pins(b_pins), .port_a_dir(a_dir),
    .port_a_out(a_out), .port_b_dir(b_dir), .port_b_out(b_out),
    .timer0_events(t0_ev), .timer1_events(t1_ev),
    .pin_change_events(pc_ev), .ext_irq_events(ext_ev),
    .ext_irq_mask(irq_mask), .nvm_address(nvm_addr));
  core_model core (.sys_clk(sys_clk), .req(req), .resp(resp));

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    {a_pins, b_pins, t0_ev, t1_ev, pc_ev, ext_ev} = '0;
    reset = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 reset = 1'b0;
    // Whole 6-bit space reads zero after reset, reserved places too
    for (int a = 0; a < 64; a++) begin
      core.access(IO_READ, 8'(a), 3'h0, 8'h00, got);
      check("reset_read", got, {1'b1, 8'h00, 1'b0});
    end
    // Store through the mirror, read by I/O, back to back
    for (int i = 0; i < 28; i++) begin
      core.access(DATA_STORE, wofs[i] + 8'h20, 3'h0, 8'hff, got);
      core.access(IO_READ, wofs[i], 3'h0, 8'h00, got);
      check("mirror_store", got, {1'b1, wmsk[i], 1'b0});
    end
    check("port_outs", {a_dir, a_out, b_dir, b_out}, 32'hffffffff);
    check("irq_mask", irq_mask, 8'h03);
    check("nvm_addr", nvm_addr, 9'h1ff);
    core.access(DATA_STORE, 8'h42, 3'h0, 8'hfe, got);
    core.idle();
    check("nvm_addr_top", nvm_addr, 9'h0ff);
    // Clear by I/O write, read through the mirror
    for (int i = 0; i < 28; i++) begin
      core.access(IO_WRITE, wofs[i], 3'h0, 8'h00, got);
      core.access(DATA_LOAD, wofs[i] + 8'h20, 3'h0, 8'h00, got);
      check("mirror_load", got, {1'b1, 8'h00, 1'b0});
    end
    check("port_outs_clr", {a_dir, a_out, b_dir, b_out}, 32'h0);
    // Bit clear on a drive register keeps the other bits
    core.access(IO_WRITE, 8'h02, 3'h0, 8'ha5, got);
    core.access(BIT_CLEAR_INSTR, 8'h02, 3'h0, 8'h00, got);
    check("port_a_clr", a_out, 8'ha4);
    // Pin registers follow pins and ignore writes
    a_pins = 8'h5a;
    b_pins = 8'ha5;
    core.access(IO_WRITE, 8'h00, 3'h0, 8'hff, got);
    core.idle();
    core.idle();
    core.access(IO_READ, 8'h00, 3'h0, 8'h00, got);
    check("pins_a", got, {1'b1, 8'h5a, 1'b0});
    core.access(DATA_LOAD, 8'h23, 3'h0, 8'h00, got);
    check("pins_b", got, {1'b1, 8'ha5, 1'b0});
    // Outside the mirror and bit ops above 0x1f give no answer
    core.access(DATA_LOAD, 8'h1f, 3'h0, 8'h00, got);
    check("load_low", got.valid, 1'b0);
    core.access(DATA_LOAD, 8'h60, 3'h0, 8'h00, got);
    check("load_ext", got.valid, 1'b0);
    core.access(DATA_STORE, 8'hff, 3'h0, 8'hff, got);
    core.access(BIT_SET_INSTR, 8'h2a, 3'h0, 8'h00, got);
    core.access(SKIP_IF_IO_BIT_CLEAR, 8'h2a, 3'h1, 8'h00, got);
    check("test_high", got.valid, 1'b0);
    core.access(IO_READ, 8'h2a, 3'h0, 8'h00, got);
    check("bitset_high", got, {1'b1, 8'h00, 1'b0});
    // Single-bit set then clear, each touching one bit only
    for (int b = 0; b < 8; b++) begin
      core.access(BIT_SET_INSTR, 8'h1e, 3'(b), 8'h00, got);
      core.access(IO_READ, 8'h1e, 3'h0, 8'h00, got);
      check("bit_set", got.data, 8'hff >> (7 - b));
    end
    for (int b = 0; b < 8; b++) begin
      core.access(BIT_CLEAR_INSTR, 8'h1e, 3'(b), 8'h00, got);
      core.access(IO_READ, 8'h1e, 3'h0, 8'h00, got);
      check("bit_clear", got.data, 8'(8'hfe << b));
    end
    // Bit test with skip on every kind
    core.access(IO_WRITE, 8'h1e, 3'h0, 8'h04, got);
    for (int i = 0; i < 4; i++) begin
      core.access(tk[i], 8'h1e, tb_bit[i], 8'h00, got);
      check("bit_test", got, {1'b1, 8'h00, tskip[i]});
    end
    // Hardware flags, cleared only by writing one
    {t0_ev, t1_ev, pc_ev, ext_ev} = '1;
    core.idle();
    {t0_ev, t1_ev, pc_ev, ext_ev} = '0;
    core.access(IO_READ, 8'h15, 3'h0, 8'h00, got);
    check("t0_flags", got.data, 8'h03);
    core.access(IO_READ, 8'h1b, 3'h0, 8'h00, got);
    check("pc_flags", got.data, 8'h03);
    core.access(IO_WRITE, 8'h16, 3'h0, 8'h00, got);
    core.access(BIT_CLEAR_INSTR, 8'h16, 3'h0, 8'h00, got);
    core.access(IO_READ, 8'h16, 3'h0, 8'h00, got);
    check("t1_keep", got.data, 8'h27);
    core.access(BIT_SET_INSTR, 8'h16, 3'h1, 8'h00, got);
    core.access(IO_READ, 8'h16, 3'h0, 8'h00, got);
    check("t1_one_bit", got.data, 8'h25);
    core.access(IO_WRITE, 8'h16, 3'h0, 8'h05, got);
    core.access(IO_READ, 8'h16, 3'h0, 8'h00, got);
    check("t1_w1c", got.data, 8'h20);
    // A new event wins over a clear in the same cycle
    ext_ev = 8'h01;
    core.access(IO_WRITE, 8'h1c, 3'h0, 8'h03, got);
    ext_ev = 8'h00;
    core.access(IO_READ, 8'h1c, 3'h0, 8'h00, got);
    check("ext_set_wins", got.data, 8'h01);
    core.access(IO_WRITE, 8'h1c, 3'h0, 8'h01, got);
    core.access(IO_READ, 8'h1c, 3'h0, 8'h00, got);
    check("ext_w1c", got.data, 8'h00);
    core.idle();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
